// *** hdl/crs_pkg.sv ***
// constants and types for the processor core register state block
package crs_pkg;
  // wishbone byte offsets of the register words
  localparam logic [7:0] OFF_PC = 8'h00;
  localparam logic [7:0] OFF_ISP = 8'h04;
  localparam logic [7:0] OFF_DTB = 8'h08;
  localparam logic [7:0] OFF_PSW = 8'h0c;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_GPR = 8'h40;
  // register file shape
  localparam int NUM_GPR = 16;
  localparam int GPR_W = 16;
  localparam int ADDR_W = 21;
  // address registers: bits 20..16 and bit 0 never store a one
  localparam logic [15:0] ADDR_LO_MASK = 16'hfffe;
  localparam logic [4:0] ADDR_TOP_ZERO = 5'h00;
  // status word field positions
  localparam int PSW_C = 0;
  localparam int PSW_T = 1;
  localparam int PSW_L = 2;
  localparam int PSW_F = 5;
  localparam int PSW_Z = 6;
  localparam int PSW_N = 7;
  localparam int PSW_E = 9;
  localparam int PSW_P = 10;
  localparam int PSW_I = 11;
  // writable status bits and values after reset
  localparam logic [15:0] PSW_MASK = 16'h0ee7;
  localparam logic [15:0] PSW_RST = 16'h0200;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;
  // registers that catch the pre-reset state
  localparam logic [3:0] GPR_ZERO = 4'h0;
  localparam logic [3:0] GPR_ONE = 4'h1;
  // operand address modes of load and store
  typedef enum logic [1:0] {
    MODE_ABS = 2'b00,
    MODE_REL = 2'b01,
    MODE_FAR = 2'b10
  } crs_mode_t;
endpackage

// *** hdl/crs_core_regs.sv ***
// architectural register state of the core with a wishbone window on it
// Operation
// - sixteen 16-bit general registers incl return, stack
// - byte operations touch only the low byte
// - address registers 21 bits, top five, bit0 zero
// - program counter holds only even addresses
// - reset copies counter bits 1-15 into register zero
// - carry flag reports add carry or subtract borrow
// - trace bit traps every instruction, cleared on entry
// - compare sets low flag on unsigned less
// - general flag reports add and subtract overflow
// - compare sets zero flag when operands equal
// - compare sets negative flag on signed less
// - enable sets, disable clears local interrupt enable
// - maskable accepted only with both enables set
// - pending bit limits trace trap to one
// - reset clears status except local enable set
// - reset saves old status word into register one
// - memory operands only for load and store
// - branch immediate is added to program counter
// - relative address is register plus displacement
// - only 64K used, far relative not supported
`timescale 1ns/10ps
module crs_core_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // general register read ports
  input wire logic [3:0] rd_a_sel_i,
  input wire logic rd_a_byte_i,
  output logic [15:0] rd_a_data_o,
  input wire logic [3:0] rd_b_sel_i,
  input wire logic rd_b_byte_i,
  output logic [15:0] rd_b_data_o,
  // general register write port
  input wire logic gpr_we_i,
  input wire logic [3:0] gpr_wsel_i,
  input wire logic gpr_wbyte_i,
  input wire logic [15:0] gpr_wdata_i,
  // program counter control
  input wire logic pc_step_i,
  input wire logic [2:0] pc_step_bytes_i,
  input wire logic pc_branch_i,
  input wire logic [15:0] pc_disp_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_load_addr_i,
  output logic [20:0] pc_o,
  // arithmetic and compare flag update
  input wire logic alu_upd_i,
  input wire logic cmp_upd_i,
  input wire logic alu_sub_i,
  input wire logic alu_cin_i,
  input wire logic alu_byte_i,
  input wire logic [15:0] alu_dst_i,
  input wire logic [15:0] alu_src_i,
  input wire logic flag_f_wr_i,
  input wire logic flag_f_val_i,
  // interrupt and trace events
  input wire logic enable_interrupts_instr_i,
  input wire logic disable_interrupts_instr_i,
  input wire logic instr_done_i,
  input wire logic trap_entry_i,
  input wire logic int_entry_i,
  input wire logic int_return_i,
  output logic maskable_ok_o,
  output logic trace_trap_o,
  // load and store operand address
  input wire logic ldst_req_i,
  input crs_pkg::crs_mode_t mem_mode_i,
  input wire logic [3:0] mem_base_sel_i,
  input wire logic [15:0] mem_disp_i,
  input wire logic [15:0] mem_abs_i,
  output logic mem_req_o,
  output logic [15:0] mem_addr_o,
  output logic mem_mode_err_o,
  // dedicated registers seen by the pipeline
  output logic [20:0] interrupt_stack_pointer_o,
  output logic [20:0] dispatch_table_base_o,
  output logic [15:0] processor_status_word_o,
  output logic [15:0] core_configuration_o
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [15:0] gpr_ff [crs_pkg::NUM_GPR]; // 14 general, return, stack
  logic [15:0] pc_ff; // low 16 bits, top five implied zero
  logic [15:0] isp_ff; // interrupt_stack_pointer low bits
  logic [15:0] dtb_ff; // dispatch_table_base low bits
  logic [15:0] psw_ff; // processor_status_word
  logic [15:0] cfg_ff; // core_configuration
  logic rst_d_ff; // reset seen last cycle
  logic ack_ff; // wishbone acknowledge
  logic [31:0] dat_ff; // wishbone read data
  logic [15:0] rd_a_ff; // read port a data
  logic [15:0] rd_b_ff; // read port b data
  logic mem_req_ff; // operand address valid
  logic [15:0] mem_addr_ff; // operand address
  logic mem_err_ff; // unsupported mode seen
  logic [15:0] nxt_pc;
  logic [15:0] nxt_psw;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  // writes commit on the edge where the master sees ack
  wire bus_wr = bus_req & wb_we_i & ack_ff;
  wire [5:0] bus_word = wb_adr_i[7:2];
  wire hit_pc = bus_word == crs_pkg::OFF_PC[7:2];
  wire hit_isp = bus_word == crs_pkg::OFF_ISP[7:2];
  wire hit_dtb = bus_word == crs_pkg::OFF_DTB[7:2];
  wire hit_psw = bus_word == crs_pkg::OFF_PSW[7:2];
  wire hit_cfg = bus_word == crs_pkg::OFF_CFG[7:2];
  wire hit_gpr = wb_adr_i[7:6] == crs_pkg::OFF_GPR[7:6];
  wire [3:0] bus_gidx = wb_adr_i[5:2];
  // only the two low byte lanes carry storage; upper lanes are dropped
  wire [15:0] bus_lanes = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire bus_pc_wr = bus_wr & hit_pc;
  wire bus_isp_wr = bus_wr & hit_isp;
  wire bus_dtb_wr = bus_wr & hit_dtb;
  wire bus_psw_wr = bus_wr & hit_psw;
  wire bus_cfg_wr = bus_wr & hit_cfg;
  wire bus_gpr_wr = bus_wr & hit_gpr;

  // merge written lanes over the old word
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [15:0] lanes);
    lane_merge = (old_v & ~lanes) | (new_v & lanes);
  endfunction

  // 21-bit views: top five bits are hard zero
  assign pc_o = {crs_pkg::ADDR_TOP_ZERO, pc_ff};
  assign interrupt_stack_pointer_o = {crs_pkg::ADDR_TOP_ZERO, isp_ff};
  assign dispatch_table_base_o = {crs_pkg::ADDR_TOP_ZERO, dtb_ff};
  assign processor_status_word_o = psw_ff;
  assign core_configuration_o = cfg_ff;

  // read mux; unmapped words answer zero with a normal ack
  wire [31:0] bus_rdata =
    hit_pc ? {11'h000, pc_o} :
    hit_isp ? {11'h000, interrupt_stack_pointer_o} :
    hit_dtb ? {11'h000, dispatch_table_base_o} :
    hit_psw ? {16'h0000, psw_ff} :
    hit_cfg ? {16'h0000, cfg_ff} :
    hit_gpr ? {16'h0000, gpr_ff[bus_gidx]} : 32'h0000_0000;

  // one wait state: ack one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req & ~ack_ff) begin
        dat_ff <= bus_rdata;
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // reset capture: only the first reset cycle saves the old state,
  // later reset cycles would otherwise overwrite it with reset values
  wire rst_first = rst_i & ~rst_d_ff;
  always_ff @(posedge clk_i) begin
    rst_d_ff <= rst_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // general registers; bus write after pipeline write so software wins
  always_ff @(posedge clk_i) begin
    if (rst_first) begin
      gpr_ff[crs_pkg::GPR_ZERO] <= {1'b0, pc_ff[15:1]};
      gpr_ff[crs_pkg::GPR_ONE] <= psw_ff;
    end else if (!rst_i) begin
      if (gpr_we_i && gpr_wbyte_i) begin
        gpr_ff[gpr_wsel_i][7:0] <= gpr_wdata_i[7:0];
      end else if (gpr_we_i) begin
        gpr_ff[gpr_wsel_i] <= gpr_wdata_i;
      end
      if (bus_gpr_wr) begin
        gpr_ff[bus_gidx] <= lane_merge(gpr_ff[bus_gidx], wb_dat_i[15:0], bus_lanes);
      end
    end
  end

  // registered read ports; byte reads see zero above the low byte
  wire [15:0] rd_a_w = rd_a_byte_i ? {8'h00, gpr_ff[rd_a_sel_i][7:0]} : gpr_ff[rd_a_sel_i];
  wire [15:0] rd_b_w = rd_b_byte_i ? {8'h00, gpr_ff[rd_b_sel_i][7:0]} : gpr_ff[rd_b_sel_i];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_a_ff <= 16'h0000;
      rd_b_ff <= 16'h0000;
    end else begin
      rd_a_ff <= rd_a_w;
      rd_b_ff <= rd_b_w;
    end
  end
  assign rd_a_data_o = rd_a_ff;
  assign rd_b_data_o = rd_b_ff;

  ////////////////////////////////////////////////////////////////////////////
  // program counter: load beats branch beats step; bit 0 forced clear
  wire [15:0] pc_branch_w = pc_ff + pc_disp_i;
  wire [15:0] pc_step_w = pc_ff + {13'h0000, pc_step_bytes_i};
  always_comb begin
    nxt_pc = pc_ff;
    if (pc_load_i) begin
      nxt_pc = pc_load_addr_i;
    end else if (pc_branch_i) begin
      nxt_pc = pc_branch_w;
    end else if (pc_step_i) begin
      nxt_pc = pc_step_w;
    end
    if (bus_pc_wr) begin
      nxt_pc = lane_merge(pc_ff, wb_dat_i[15:0], bus_lanes);
    end
    nxt_pc = nxt_pc & crs_pkg::ADDR_LO_MASK;
  end

  // address registers; isp alignment is software's duty, bit 0 is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_ff <= crs_pkg::PC_RST;
      isp_ff <= crs_pkg::PTR_RST;
      dtb_ff <= crs_pkg::PTR_RST;
      cfg_ff <= crs_pkg::CFG_RST;
    end else begin
      pc_ff <= nxt_pc;
      if (bus_isp_wr) begin
        isp_ff <= lane_merge(isp_ff, wb_dat_i[15:0], bus_lanes) & crs_pkg::ADDR_LO_MASK;
      end
      if (bus_dtb_wr) begin
        dtb_ff <= lane_merge(dtb_ff, wb_dat_i[15:0], bus_lanes) & crs_pkg::ADDR_LO_MASK;
      end
      if (bus_cfg_wr) begin
        cfg_ff <= lane_merge(cfg_ff, wb_dat_i[15:0], bus_lanes);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic flags for add and subtract, word or byte
  wire cin = alu_cin_i & psw_ff[crs_pkg::PSW_C];
  wire [16:0] add_w = {1'b0, alu_dst_i} + {1'b0, alu_src_i} + {16'h0000, cin};
  wire [16:0] sub_w = {1'b0, alu_dst_i} - {1'b0, alu_src_i} - {16'h0000, cin};
  wire [8:0] addb_w = {1'b0, alu_dst_i[7:0]} + {1'b0, alu_src_i[7:0]} + {8'h00, cin};
  wire [8:0] subb_w = {1'b0, alu_dst_i[7:0]} - {1'b0, alu_src_i[7:0]} - {8'h00, cin};
  wire [16:0] res_w = alu_sub_i ? sub_w : add_w;
  wire [8:0] resb_w = alu_sub_i ? subb_w : addb_w;
  // top bit of the widened result is carry out, or borrow on subtract
  wire carry_w = alu_byte_i ? resb_w[8] : res_w[16];
  wire sgn_d = alu_byte_i ? alu_dst_i[7] : alu_dst_i[15];
  wire sgn_s = alu_byte_i ? alu_src_i[7] : alu_src_i[15];
  wire sgn_r = alu_byte_i ? resb_w[7] : res_w[15];
  wire ovf_w = alu_sub_i ? ((sgn_d != sgn_s) & (sgn_r != sgn_d)) :
                           ((sgn_d == sgn_s) & (sgn_r != sgn_d));
  // compare flags: destination against source
  wire cmp_l_w = alu_byte_i ? (alu_dst_i[7:0] < alu_src_i[7:0]) : (alu_dst_i < alu_src_i);
  wire cmp_n_w = alu_byte_i ? ($signed(alu_dst_i[7:0]) < $signed(alu_src_i[7:0])) :
                              ($signed(alu_dst_i) < $signed(alu_src_i));
  wire cmp_z_w = alu_byte_i ? (alu_dst_i[7:0] == alu_src_i[7:0]) : (alu_dst_i == alu_src_i);
  // a trace trap is due once per instruction while none is pending
  wire trace_due = instr_done_i & psw_ff[crs_pkg::PSW_T] & ~psw_ff[crs_pkg::PSW_P];

  ////////////////////////////////////////////////////////////////////////////
  // status word next value; later lines take priority
  always_comb begin
    nxt_psw = psw_ff;
    if (alu_upd_i) begin
      nxt_psw[crs_pkg::PSW_C] = carry_w;
      nxt_psw[crs_pkg::PSW_F] = ovf_w;
    end
    if (cmp_upd_i) begin
      nxt_psw[crs_pkg::PSW_L] = cmp_l_w;
      nxt_psw[crs_pkg::PSW_Z] = cmp_z_w;
      nxt_psw[crs_pkg::PSW_N] = cmp_n_w;
    end
    if (flag_f_wr_i) begin
      nxt_psw[crs_pkg::PSW_F] = flag_f_val_i;
    end
    if (enable_interrupts_instr_i) begin
      nxt_psw[crs_pkg::PSW_E] = 1'b1;
    end
    if (disable_interrupts_instr_i) begin
      nxt_psw[crs_pkg::PSW_E] = 1'b0;
    end
    if (int_return_i) begin
      nxt_psw[crs_pkg::PSW_I] = 1'b1;
    end
    if (trace_due) begin
      nxt_psw[crs_pkg::PSW_P] = 1'b1;
    end
    // entry takes the pending trap, so pending clears with trace
    if (trap_entry_i | int_entry_i) begin
      nxt_psw[crs_pkg::PSW_T] = 1'b0;
      nxt_psw[crs_pkg::PSW_P] = 1'b0;
    end
    if (int_entry_i) begin
      nxt_psw[crs_pkg::PSW_I] = 1'b0;
    end
    if (bus_psw_wr) begin
      nxt_psw = lane_merge(psw_ff, wb_dat_i[15:0], bus_lanes);
    end
    nxt_psw = nxt_psw & crs_pkg::PSW_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw_ff <= crs_pkg::PSW_RST;
    end else begin
      psw_ff <= nxt_psw;
    end
  end
  assign maskable_ok_o = psw_ff[crs_pkg::PSW_E] & psw_ff[crs_pkg::PSW_I];
  assign trace_trap_o = psw_ff[crs_pkg::PSW_P];

  ////////////////////////////////////////////////////////////////////////////
  // operand address formation, load and store only
  wire [15:0] rel_addr_w = gpr_ff[mem_base_sel_i] + mem_disp_i;
  // far-relative and the spare code are refused: 64K space only
  wire mode_ok = (mem_mode_i == crs_pkg::MODE_ABS) | (mem_mode_i == crs_pkg::MODE_REL);
  wire [15:0] nxt_mem_addr = (mem_mode_i == crs_pkg::MODE_REL) ? rel_addr_w : mem_abs_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_ff <= 1'b0;
      mem_err_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
    end else begin
      mem_req_ff <= ldst_req_i & mode_ok;
      mem_err_ff <= ldst_req_i & ~mode_ok;
      if (ldst_req_i & mode_ok) begin
        mem_addr_ff <= nxt_mem_addr;
      end
    end
  end
  assign mem_req_o = mem_req_ff;
  assign mem_addr_o = mem_addr_ff;
  assign mem_mode_err_o = mem_err_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks; the capture check looks back one edge from the first reset cycle,
  // so a power-up reset with unknown old state never arms it
  wire after_rst = !rst_i && rst_d_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_addr_zero_bits;
    pc_o[0] == 1'b0 && pc_o[20:16] == 5'h00 && interrupt_stack_pointer_o[0] == 1'b0;
  endproperty
  a_addr_zero_bits: assert property (p_addr_zero_bits) else $error("address zero bits set");
  property p_reset_capture;
    disable iff (1'b0)
    rst_first |=> gpr_ff[0] == {1'b0, $past(pc_ff[15:1])} && gpr_ff[1] == $past(psw_ff)
                  && pc_ff == 16'h0000;
  endproperty
  a_reset_capture: assert property (p_reset_capture) else $error("reset capture wrong");
  property p_psw_reset;
    after_rst |-> psw_ff == 16'h0200 ##1 1'b1;
  endproperty
  a_psw_reset: assert property (p_psw_reset) else $error("status reset value wrong");
  property p_byte_keep;
    gpr_we_i && gpr_wbyte_i && !bus_gpr_wr |=>
      gpr_ff[$past(gpr_wsel_i)] == {$past(gpr_ff[gpr_wsel_i][15:8]), $past(gpr_wdata_i[7:0])};
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("byte write touched high byte");
  property p_carry;
    alu_upd_i && !bus_psw_wr |=> psw_ff[0] == $past(carry_w) && psw_ff[5] == $past(ovf_w)
                                 || $past(flag_f_wr_i);
  endproperty
  a_carry: assert property (p_carry) else $error("carry or overflow wrong");
  property p_cmp;
    cmp_upd_i && !bus_psw_wr |=> psw_ff[2] == $past(cmp_l_w) && psw_ff[6] == $past(cmp_z_w)
                                 && psw_ff[7] == $past(cmp_n_w);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flags wrong");
  property p_trace_once;
    trace_due && !trap_entry_i && !int_entry_i && !bus_psw_wr |=> trace_trap_o
      ##0 (trace_trap_o throughout (!trap_entry_i && !int_entry_i && !bus_psw_wr)[*2]);
  endproperty
  a_trace_once: assert property (p_trace_once) else $error("trace pending lost");
  property p_entry_clears;
    (trap_entry_i || int_entry_i) && !bus_psw_wr |=> !psw_ff[1] && !trace_trap_o;
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("entry kept trace");
  property p_int_entry_mask;
    int_entry_i && !int_return_i && !bus_psw_wr |=> !maskable_ok_o;
  endproperty
  a_int_entry_mask: assert property (p_int_entry_mask) else $error("mask not closed");
  property p_ei_di;
    enable_interrupts_instr_i && !disable_interrupts_instr_i && !bus_psw_wr |=> psw_ff[9];
  endproperty
  a_ei_di: assert property (p_ei_di) else $error("enable bit not set");
  property p_rel_addr;
    ldst_req_i && mem_mode_i == crs_pkg::MODE_REL |=> mem_req_o && mem_addr_o == $past(rel_addr_w);
  endproperty
  a_rel_addr: assert property (p_rel_addr) else $error("relative address wrong");
  property p_far_refused;
    ldst_req_i && mem_mode_i == crs_pkg::MODE_FAR |=> mem_mode_err_o && !mem_req_o;
  endproperty
  a_far_refused: assert property (p_far_refused) else $error("far mode not refused");
  property p_ack_pulse;
    bus_req && !ack_ff |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");

  c_trace_taken: cover property (trace_due ##1 trap_entry_i);
  c_byte_write: cover property (gpr_we_i && gpr_wbyte_i);
  c_bus_psw_write: cover property (bus_psw_wr);
  c_rel_load: cover property (ldst_req_i && mem_mode_i == crs_pkg::MODE_REL);
endmodule

// *** dv/crs_pipe_model.sv ***
// behavioural decode and execute stage that drives the register state block
`timescale 1ns/10ps
module crs_pipe_model (
  input wire logic clk_i,
  output logic gpr_we_i, pc_step_i, pc_branch_i, pc_load_i, alu_upd_i, cmp_upd_i, flag_f_wr_i,
  output logic enable_interrupts_instr_i, disable_interrupts_instr_i, instr_done_i,
  output logic trap_entry_i, int_entry_i, int_return_i, ldst_req_i, rd_a_byte_i, gpr_wbyte_i,
  output logic alu_sub_i,
  output logic [3:0] rd_a_sel_i, gpr_wsel_i, mem_base_sel_i,
  output logic [2:0] pc_step_bytes_i,
  output logic [15:0] gpr_wdata_i, pc_disp_i, pc_load_addr_i, alu_dst_i, alu_src_i,
  output logic [15:0] mem_disp_i, mem_abs_i,
  output crs_pkg::crs_mode_t mem_mode_i
);
  logic [13:0] st_ff = '0; // strobes, msb is the register write
  logic [15:0] x_ff = '0; // first operand, shared by every field that takes one
  logic [15:0] y_ff = '0; // second operand or address mode
  logic [3:0] r_ff = '0; // register index
  logic b_ff = 1'b0; // byte write or subtract
  ////////////////////////////////////////////////////////////////////////////////
  // fan the few operand registers out to the pipeline fields
  assign {gpr_we_i, pc_step_i, pc_branch_i, pc_load_i, alu_upd_i, cmp_upd_i, flag_f_wr_i,
    enable_interrupts_instr_i, disable_interrupts_instr_i, instr_done_i, trap_entry_i,
    int_entry_i, int_return_i, ldst_req_i} = st_ff;
  assign {gpr_wdata_i, pc_disp_i, pc_load_addr_i, alu_dst_i, mem_disp_i, mem_abs_i} = {6{x_ff}};
  assign {gpr_wsel_i, mem_base_sel_i} = {2{r_ff}};
  assign {gpr_wbyte_i, alu_sub_i} = {2{b_ff}};
  assign pc_step_bytes_i = x_ff[2:0];
  assign alu_src_i = y_ff;
  assign mem_mode_i = crs_pkg::crs_mode_t'(y_ff[1:0]);
  initial {rd_a_sel_i, rd_a_byte_i} = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // one operation: strobes stand exactly one edge, operands stay put afterwards
  task automatic run(input logic [13:0] m, input logic [3:0] r, input logic b,
                     input logic [15:0] x, input logic [15:0] y);
    @(posedge clk_i);
    st_ff <= m;
    r_ff <= r;
    b_ff <= b;
    x_ff <= x;
    y_ff <= y;
    @(posedge clk_i);
    st_ff <= '0;
    #1;
  endtask
  // register read port, data is registered so look one edge later
  task automatic rd(input logic [3:0] s, input logic b);
    @(posedge clk_i);
    rd_a_sel_i <= s;
    rd_a_byte_i <= b;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// *** dv/tb_crs_core_regs.sv ***
// self-checking bench for the core register state block
`timescale 1ns/10ps
module tb_crs_core_regs;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rd_b_byte_i;
  logic alu_cin_i, alu_byte_i, flag_f_val_i, maskable_ok_o, trace_trap_o, mem_req_o;
  logic mem_mode_err_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, rd_b_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [15:0] rd_a_data_o, rd_b_data_o, processor_status_word_o, core_configuration_o;
  logic [15:0] mem_addr_o;
  logic [20:0] pc_o, interrupt_stack_pointer_o, dispatch_table_base_o;
  wire gpr_we_i, pc_step_i, pc_branch_i, pc_load_i, alu_upd_i, cmp_upd_i, flag_f_wr_i;
  wire enable_interrupts_instr_i, disable_interrupts_instr_i, instr_done_i, trap_entry_i;
  wire int_entry_i, int_return_i, ldst_req_i, rd_a_byte_i, gpr_wbyte_i, alu_sub_i;
  wire [3:0] rd_a_sel_i, gpr_wsel_i, mem_base_sel_i;
  wire [2:0] pc_step_bytes_i;
  wire [15:0] gpr_wdata_i, pc_disp_i, pc_load_addr_i, alu_dst_i, alu_src_i, mem_disp_i, mem_abs_i;
  wire crs_pkg::crs_mode_t mem_mode_i;
  int miscompares = 0;
  int checks_done = 0;
  // operand and expectation tables: four arithmetic rows then four compares
  logic [15:0] td [8] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0, 16'h1, 16'hffff, 16'h5, 16'h1};
  logic [15:0] ts [8] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h2, 16'h1, 16'h5, 16'hffff};
  logic [4:0] te [8] = '{5'h02, 5'h02, 5'h01, 5'h01, 5'h14, 5'h10, 5'h08, 5'h04};
  logic [7:0] tsub = 8'h0a; // rows that subtract
  logic [13:0] em [8] = '{14'h10, 14'h10, 14'h8, 14'h2, 14'h20, 14'h40, 14'h4, 14'h10};
  logic [5:0] ee [8] = '{6'h1d, 6'h1d, 6'h08, 6'h2a, 6'h20, 6'h2a, 6'h08, 6'h08};
  logic [17:0] le [4] = '{18'h2000c, 18'h2100c, 18'h10000, 18'h10000};
  logic [15:0] px [3] = '{16'h2, 16'hfffe, 16'h4001};
  logic [31:0] pe [3] = '{32'h1236, 32'h1234, 32'h4000};
  crs_core_regs u_dut (.*);
  crs_pipe_model u_pipe (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // compare, count, report at once
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // classic single cycle, held until ack is sampled, bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 16) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // main sequence; b port, carry-in, byte alu and flag value are tied
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
    {wb_sel_i, rd_b_sel_i, rd_b_byte_i, alu_cin_i, alu_byte_i, flag_f_val_i} = 12'hf5_1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(crs_pkg::OFF_PSW, 32'h200);
    rdc(crs_pkg::OFF_CFG, 32'h0);
    rdc(8'h3c, 32'h0);
    wb(1'b1, crs_pkg::OFF_ISP, 32'hffe7ff);
    rdc(crs_pkg::OFF_ISP, 32'he7fe);
    chk(32'(interrupt_stack_pointer_o), 32'he7fe);
    wb(1'b1, crs_pkg::OFF_DTB, 32'h1235);
    rdc(crs_pkg::OFF_DTB, 32'h1234);
    wb(1'b1, crs_pkg::OFF_PC, 32'h1f1235);
    rdc(crs_pkg::OFF_PC, 32'h1234);
    // step, branch backwards, odd load
    for (int i = 0; i < 3; i++) begin
      u_pipe.run(14'h1000 >> i, 4'h0, 1'b0, px[i], 16'h0);
      chk(32'(pc_o), pe[i]);
    end
    // overflow, carry, then the compare flags; masked to the fields each updates
    for (int i = 0; i < 8; i++) begin
      u_pipe.run(i < 4 ? 14'h200 : 14'h100, 4'h0, tsub[i], td[i], ts[i]);
      chk({processor_status_word_o[7:5], processor_status_word_o[2], processor_status_word_o[0]}
        & (i < 4 ? 5'h05 : 5'h1a), {te[i][4:3], te[i][1], te[i][2], te[i][0]});
    end
    u_pipe.run(14'h80, 4'h0, 1'b0, 16'h0, 16'h0);
    chk(processor_status_word_o[5], 1'b1);
    wb(1'b1, crs_pkg::OFF_PSW, 32'h0202);
    // trace, trap entry, interrupt return, disable, enable, interrupt entry
    for (int i = 0; i < 8; i++) begin
      u_pipe.run(em[i], 4'h0, 1'b0, 16'h0, 16'h0);
      chk({processor_status_word_o[11:9], processor_status_word_o[1], maskable_ok_o,
        trace_trap_o}, ee[i]);
    end
    wb(1'b1, 8'h4c, 32'habcd);
    u_pipe.run(14'h2000, 4'h3, 1'b1, 16'h5512, 16'h0);
    rdc(8'h4c, 32'hab12);
    u_pipe.rd(4'h3, 1'b1);
    chk(rd_a_data_o, 32'h12);
    wb(1'b1, 8'h54, 32'h1000);
    wb(1'b1, 8'h7c, 32'hbeef);
    u_pipe.rd(4'hf, 1'b0);
    chk(rd_a_data_o, 32'hbeef);
    chk(rd_b_data_o, 32'h1000);
    // absolute, relative, far and illegal operand modes
    for (int i = 0; i < 4; i++) begin
      u_pipe.run(14'h1, 4'h5, 1'b0, 16'h000c, 16'(i));
      chk({mem_req_o, mem_mode_err_o, mem_addr_o & {16{mem_req_o}}}, le[i]);
    end
    // second reset in mid-run captures the old counter and status word
    wb(1'b1, crs_pkg::OFF_PC, 32'h1234);
    wb(1'b1, crs_pkg::OFF_PSW, 32'h0ee7);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h40, 32'h091a);
    rdc(8'h44, 32'h0ee7);
    rdc(crs_pkg::OFF_PSW, 32'h200);
    chk(32'(pc_o), 32'h0);
    rdc(8'h4c, 32'hab12);
    conclude();
  end
endmodule
